// >>> rtl/dsa_pkg.sv
// Shared constants for the data-space access and stack check unit
package dsa_pkg;
    // ----------------------------------------
    // Address space
    // ----------------------------------------
    localparam logic [15:0] DSA_NEAR_MASK = 16'h1FFF;
    localparam logic [15:0] DSA_SFR_END = 16'h0800;
    localparam logic [15:0] DSA_Y_BASE = 16'h0C00;
    localparam logic [15:0] DSA_Y_LAST = 16'h0FFF;
    localparam logic [15:0] DSA_MEM_LAST = 16'h0FFF;
    localparam int DSA_BREV_W = 8;
    localparam logic [15:0] DSA_STEP_BYTE = 16'h0001;
    localparam logic [15:0] DSA_STEP_WORD = 16'h0002;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] DSA_SP_RST = 16'h0800;
    localparam logic [1:0] DSA_FAULT_RST = 2'h0;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [1:0] DSA_REG_STACK_LIMIT = 2'h0;
    localparam logic [1:0] DSA_REG_SP = 2'h1;
    localparam logic [1:0] DSA_REG_FAULT = 2'h2;
    // ----------------------------------------
    // Modes
    // ----------------------------------------
    localparam logic [1:0] DSA_DIR_IND = 2'h0;
    localparam logic [1:0] DSA_DIR_NEAR = 2'h1;
    localparam logic [1:0] DSA_DIR_LONG = 2'h2;
    localparam logic [1:0] DSA_PUSH_DATA = 2'h0;
    localparam logic [1:0] DSA_PUSH_CALL = 2'h1;
    localparam logic [1:0] DSA_PUSH_EXC = 2'h2;
endpackage

// >>> rtl/dsa_agu.sv
// Address generation: bit reversal, post-modify step, alignment check
`timescale 1ns/1ps
module dsa_agu import dsa_pkg::*; (
    input wire logic [15:0] ea_in,
    input wire logic byte_op,
    input wire logic brev_en,
    input wire logic wr,
    output logic [15:0] ea_out,
    output logic [15:0] ea_next,
    output logic misalign
);
    logic [15:0] rev;

    // R2: reverse writes only
    genvar i;
    generate
        for (i = 1; i <= DSA_BREV_W; i++)
        begin : g_rev
            assign rev[i] = ea_in[DSA_BREV_W + 1 - i];
        end
    endgenerate
    assign rev[0] = ea_in[0];
    assign rev[15:DSA_BREV_W + 1] = ea_in[15:DSA_BREV_W + 1];
    assign ea_out = (brev_en && wr) ? rev : ea_in;
    // R9: step scales with size
    assign ea_next = ea_in + (byte_op ? DSA_STEP_BYTE : DSA_STEP_WORD);
    // R10: odd word address
    assign misalign = !byte_op && ea_out[0];
endmodule // dsa_agu

// >>> rtl/dsa_lane.sv
// Byte lane steering for reads and writes, and register widening
`timescale 1ns/1ps
module dsa_lane (
    input wire logic [15:0] rd_word,
    input wire logic rd_hi,
    input wire logic rd_byte,
    input wire logic [15:0] old_reg,
    output logic [15:0] rd_val,
    output logic [15:0] merged,
    input wire logic [15:0] wdata,
    input wire logic wr_hi,
    input wire logic wr_byte,
    input wire logic wr_en,
    output logic [1:0] we,
    output logic [15:0] lane_wdata,
    input wire logic [15:0] ext_src,
    input wire logic ext_sign,
    output logic [15:0] ext_val
);
    logic [7:0] sel;

    // R7: byte lands on low lane
    assign sel = rd_hi ? rd_word[15:8] : rd_word[7:0];
    assign rd_val = rd_byte ? {8'h00, sel} : rd_word;
    // R11: high byte kept
    assign merged = rd_byte ? {old_reg[15:8], sel} : rd_word;
    // R8: one lane strobe per byte
    assign we = !wr_en ? 2'h0 : !wr_byte ? 2'h3 : (wr_hi ? 2'h2 : 2'h1);
    assign lane_wdata = wr_byte ? {wdata[7:0], wdata[7:0]} : wdata;
    // R12: widen signed or unsigned
    assign ext_val = ext_sign ? {{8{ext_src[7]}}, ext_src[7:0]} : {8'h00, ext_src[7:0]};
endmodule // dsa_lane

// >>> rtl/dsa_top.sv
// Data-space access unit with X/Y buses and software stack checks
// Contract
// R1: All data-space writes go over the X write bus only.
// R2: Bit-reversed addressing applies only to X-space writes.
// R3: Multiply-accumulate class reads X and Y concurrently, each pointer pair own space.
// R4: Y bus never writes; accumulator write-back uses X bus anywhere.
// R5: Unimplemented or wrong-space reads return all zeros.
// R6: Effective addresses are 16-bit byte addresses, 64 KB range.
// R7: Byte read fetches word, bit zero selects byte, low lane; Y words only.
// R8: Byte write strobes only its lane; lanes share word decode.
// R9: Post-increment steps one for bytes, two for words.
// R10: Odd word access traps; faulting write suppressed, read completes.
// R11: Byte load into working register keeps high byte.
// R12: Provide sign-extend and zero-extend of a byte.
// R13: Near direct field of 13 bits reaches 0x0000 to 0x1FFF.
// R14: Move direct uses full 16-bit address field.
// R15: X/Y boundary fixed in hardware.
// R16: Stack pointer points at next free word, grows up.
// R17: Call pushes program counter high part with high byte clear.
// R18: Exception push places status low byte in high byte.
// R19: Stack limit undefined after reset, bit zero reads zero; here bit zero is clear only after a limit write.
// R20: Push at limit no trap; next push traps.
// R21: Stack address below 0x0800 raises stack error.
// R22: Software avoids stack read right after limit write.
// R23: Address and stack errors are separate one-cycle pulses.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module dsa_top import dsa_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire logic acc_byte,
    input wire logic [1:0] acc_dir_mode,
    input wire logic [15:0] acc_ea,
    input wire logic acc_brev,
    input wire logic acc_postinc,
    input wire logic [15:0] acc_wdata,
    input wire logic [15:0] acc_wreg_old,
    input wire logic mac_rd,
    input wire logic [15:0] mac_x_ea,
    input wire logic [15:0] mac_y_ea,
    input wire logic stk_push,
    input wire logic stk_pop,
    input wire logic [1:0] stk_kind,
    input wire logic [15:0] stk_wdata,
    input wire logic [7:0] pc_upper,
    input wire logic [7:0] status_low_byte,
    input wire logic ext_valid,
    input wire logic ext_sign,
    input wire logic [15:0] ext_src,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] mem_x_rdata,
    input wire logic [15:0] mem_y_rdata,
    output logic [15:0] reg_rdata_q,
    output logic [14:0] mem_x_addr_q,
    output logic mem_x_re_q,
    output logic [1:0] mem_x_we_q,
    output logic [15:0] mem_x_wdata_q,
    output logic [14:0] mem_y_addr_q,
    output logic mem_y_re_q,
    output logic [15:0] x_rdata_q,
    output logic [15:0] wreg_new_q,
    output logic rd_valid_q,
    output logic [15:0] y_rdata_q,
    output logic y_valid_q,
    output logic [15:0] ptr_next_q,
    output logic [15:0] ext_result_q,
    output logic addr_err_q,
    output logic stack_err_q
);
    logic [15:0] dir_ea, acc_ea_eff, acc_ea_next, stk_ea, x_ea, stk_word;
    logic [15:0] sp_q, stack_limit_q, rd_val, merged, lane_wdata, ext_val;
    logic [15:0] old_q1;
    logic [1:0] fault_q, we;
    logic acc_misal, use_stk, use_acc, use_mac, x_rd, x_wr, x_byte, misal;
    logic x_unimpl, x_zero, y_zero, stk_err, lim_over;
    logic rd_q1, zero_q1, hi_q1, byte_q1, yrd_q1, yzero_q1;

    // ----------------------------------------
    // Effective address
    // ----------------------------------------
    // R13: near field reaches low 8 KB
    // R14: long field covers whole X
    assign dir_ea = (acc_dir_mode == DSA_DIR_NEAR) ? (acc_ea & DSA_NEAR_MASK) : acc_ea;

    // R6: all addresses are 16-bit byte addresses
    dsa_agu u_agu (
        .ea_in(dir_ea),
        .byte_op(acc_byte),
        .brev_en(acc_brev),
        .wr(acc_wr),
        .ea_out(acc_ea_eff),
        .ea_next(acc_ea_next),
        .misalign(acc_misal)
    );

    // ----------------------------------------
    // Stack address and checks
    // ----------------------------------------
    // R16: push at free word, pop predecrements
    assign stk_ea = stk_push ? sp_q : sp_q - DSA_STEP_WORD;
    // R20: equal to limit is still legal
    assign lim_over = stk_push && (sp_q > stack_limit_q);
    // R21: guard the register area
    assign stk_err = lim_over || ((stk_push || stk_pop) && (stk_ea < DSA_SFR_END));

    // R17: upper byte forced clear
    // R18: status byte joins the push
    assign stk_word = (stk_kind == DSA_PUSH_CALL) ? {8'h00, pc_upper}
        : (stk_kind == DSA_PUSH_EXC) ? {status_low_byte, pc_upper}
        : stk_wdata;

    // ----------------------------------------
    // X bus arbitration
    // ----------------------------------------
    // Stack wins, then plain access, then prefetch; the pipeline issues one
    assign use_stk = stk_push || stk_pop;
    assign use_acc = !use_stk && (acc_rd || acc_wr);
    assign use_mac = !use_stk && !use_acc && mac_rd;
    assign x_ea = use_stk ? stk_ea : (use_acc ? acc_ea_eff : mac_x_ea);
    assign x_rd = stk_pop || (use_acc && acc_rd) || use_mac;
    // R1: every store is routed through the X write port
    // R4: accumulator write-back may hit any address
    assign x_wr = stk_push || (use_acc && acc_wr);
    assign x_byte = use_acc && acc_byte;
    assign misal = use_acc && acc_misal;
    assign x_unimpl = x_ea > DSA_MEM_LAST;
    // R15: boundary comes from constants only
    // R5: wrong space or missing memory reads zero
    assign x_zero = x_unimpl || (use_mac && x_ea >= DSA_Y_BASE && x_ea <= DSA_Y_LAST);
    assign y_zero = mac_y_ea < DSA_Y_BASE || mac_y_ea > DSA_Y_LAST;

    dsa_lane u_lane (
        .rd_word(mem_x_rdata),
        .rd_hi(hi_q1),
        .rd_byte(byte_q1),
        .old_reg(old_q1),
        .rd_val(rd_val),
        .merged(merged),
        .wdata(use_stk ? stk_word : acc_wdata),
        .wr_hi(x_ea[0]),
        .wr_byte(x_byte),
        // R10: misaligned store dropped
        .wr_en(x_wr && !misal && !x_unimpl),
        .we(we),
        .lane_wdata(lane_wdata),
        .ext_src(ext_src),
        .ext_sign(ext_sign),
        .ext_val(ext_val)
    );

    // ----------------------------------------
    // Memory request stage
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_x_addr_q <= 15'h0000;
            mem_x_re_q <= 1'b0;
            mem_x_we_q <= 2'h0;
            mem_x_wdata_q <= 16'h0000;
            rd_q1 <= 1'b0;
            zero_q1 <= 1'b0;
            hi_q1 <= 1'b0;
            byte_q1 <= 1'b0;
            old_q1 <= 16'h0000;
        end
        else if (ce)
        begin
            // R8: one word decode for both lanes
            mem_x_addr_q <= x_ea[15:1];
            mem_x_re_q <= x_rd && !x_zero;
            mem_x_we_q <= we;
            mem_x_wdata_q <= lane_wdata;
            rd_q1 <= x_rd;
            zero_q1 <= x_zero;
            hi_q1 <= x_ea[0];
            byte_q1 <= x_byte;
            old_q1 <= acc_wreg_old;
        end
    end

    // R3: Y prefetch runs beside the X read
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_y_addr_q <= 15'h0000;
            mem_y_re_q <= 1'b0;
            yrd_q1 <= 1'b0;
            yzero_q1 <= 1'b0;
        end
        else if (ce)
        begin
            // R7: Y path is word only, bit zero ignored
            mem_y_addr_q <= mac_y_ea[15:1];
            mem_y_re_q <= mac_rd && !y_zero;
            yrd_q1 <= mac_rd;
            yzero_q1 <= y_zero;
        end
    end

    // ----------------------------------------
    // Read return stage
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            x_rdata_q <= 16'h0000;
            wreg_new_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            y_rdata_q <= 16'h0000;
            y_valid_q <= 1'b0;
        end
        else if (ce)
        begin
            rd_valid_q <= rd_q1;
            y_valid_q <= yrd_q1;
            if (rd_q1)
            begin
                // R5: zero data on an invalid read
                x_rdata_q <= zero_q1 ? 16'h0000 : rd_val;
                wreg_new_q <= zero_q1 ? (byte_q1 ? {old_q1[15:8], 8'h00} : 16'h0000) : merged;
            end
            if (yrd_q1)
                y_rdata_q <= yzero_q1 ? 16'h0000 : mem_y_rdata;
        end
    end

    // ----------------------------------------
    // Pointer, widening and trap pulses
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_next_q <= 16'h0000;
            ext_result_q <= 16'h0000;
            addr_err_q <= 1'b0;
            stack_err_q <= 1'b0;
        end
        else if (ce)
        begin
            if (acc_postinc && use_acc)
                ptr_next_q <= acc_ea_next;
            if (ext_valid)
                ext_result_q <= ext_val;
            // R23: separate single-cycle requests
            addr_err_q <= misal;
            stack_err_q <= use_stk && stk_err;
        end
    end

    // ----------------------------------------
    // Stack pointer and fault flags
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sp_q <= DSA_SP_RST;
        end
        else if (ce)
        begin
            // R16: push adds two, pop subtracts two
            if (stk_push)
            begin
                sp_q <= sp_q + DSA_STEP_WORD;
            end
            else if (stk_pop)
            begin
                sp_q <= stk_ea;
            end
            else if (reg_wr && reg_addr == DSA_REG_SP)
            begin
                sp_q <= {reg_wdata[15:1], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fault_q <= DSA_FAULT_RST;
        end
        else if (ce)
        begin
            // New fault beats a write-one-to-clear in the same cycle
            fault_q <= (fault_q & ~((reg_wr && reg_addr == DSA_REG_FAULT) ? reg_wdata[1:0] : 2'h0))
                | {use_stk && stk_err, misal};
        end
    end

    // R19: limit has no reset value; bit zero cleared on each write
    // R22: a limit write takes effect on the very next push anyway
    always_ff @(posedge clk)
    begin
        if (ce && reg_wr && reg_addr == DSA_REG_STACK_LIMIT)
        begin
            stack_limit_q <= {reg_wdata[15:1], 1'b0};
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata_q <= 16'h0000;
        end
        else if (ce && reg_rd)
        begin
            unique case (reg_addr)
                DSA_REG_STACK_LIMIT: reg_rdata_q <= stack_limit_q;
                DSA_REG_SP: reg_rdata_q <= sp_q;
                DSA_REG_FAULT: reg_rdata_q <= {14'h0000, fault_q};
                default: reg_rdata_q <= 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_bad_read;
        ce && x_rd && x_zero ##1 ce;
    endsequence

    xbus_write_a: assert property (|mem_x_we_q && $past(ce) |-> $past(x_wr)) // R1
        else $error("store without X write request");
    brev_read_a: assert property (acc_brev && !acc_wr |-> acc_ea_eff == dir_ea) // R2
        else $error("bit reversal on a read");
    mac_dual_a: assert property (ce && use_mac && !x_zero && !y_zero |=> mem_x_re_q && mem_y_re_q) // R3
        else $error("prefetch not concurrent");
    zero_read_a: assert property (s_bad_read |=> x_rdata_q == 16'h0000) // R5
        else $error("invalid read not zero");
    byte_lane_a: assert property (ce && x_wr && x_byte && !x_unimpl
        |=> $onehot(mem_x_we_q) && mem_x_we_q[1] == $past(x_ea[0])) // R8
        else $error("byte write strobe wrong");
    post_step_a: assert property (ce && acc_postinc && use_acc
        |=> ptr_next_q == $past(dir_ea) + ($past(acc_byte) ? 16'h0001 : 16'h0002)) // R9
        else $error("post increment step wrong");
    misalign_a: assert property (ce && misal |=> addr_err_q && mem_x_we_q == 2'h0) // R10
        else $error("misaligned access not trapped");
    call_push_a: assert property (ce && stk_push && stk_kind == DSA_PUSH_CALL
        |=> mem_x_wdata_q[15:8] == 8'h00) // R17
        else $error("call push high byte set");
    sp_push_a: assert property (ce && stk_push |=> sp_q == $past(sp_q) + 16'h0002) // R16
        else $error("push did not advance pointer");
    limit_eq_a: assert property (ce && stk_push && sp_q == stack_limit_q && sp_q >= DSA_SFR_END
        |=> !stack_err_q) // R20
        else $error("push at limit trapped");
    sfr_guard_a: assert property (ce && use_stk && stk_ea < DSA_SFR_END |=> stack_err_q) // R21
        else $error("underflow not trapped");
    err_pulse_a: assert property (addr_err_q && ce ##1 ce && !$past(misal) |-> !addr_err_q) // R23
        else $error("address error not a pulse");
endmodule // dsa_top

// >>> verification/dsa_mem_model.sv
// Behavioural data memory on the far side of the access unit
`timescale 1ns/1ps
module dsa_mem_model (
    input wire logic clk,
    input wire logic [14:0] x_addr,
    input wire logic x_re,
    input wire logic [1:0] x_we,
    input wire logic [15:0] x_wdata,
    input wire logic [14:0] y_addr,
    input wire logic y_re,
    output logic [15:0] x_rdata,
    output logic [15:0] y_rdata
);
    logic [15:0] mem [0:2047];

    // ----------------------------------------
    // Write port
    // ----------------------------------------
    // lane writes, shared decode
    always @(posedge clk)
    begin
        if (x_we[0])
            mem[x_addr[10:0]][7:0] <= x_wdata[7:0];
        if (x_we[1])
            mem[x_addr[10:0]][15:8] <= x_wdata[15:8];
    end

    // ----------------------------------------
    // Read ports
    // ----------------------------------------
    // Asynchronous read: the unit captures data one edge after its address
    // An idle port shows the inverted word, so stale data never looks valid
    assign x_rdata = x_re ? mem[x_addr[10:0]] : ~mem[x_addr[10:0]];
    assign y_rdata = y_re ? mem[y_addr[10:0]] : ~mem[y_addr[10:0]];
endmodule // dsa_mem_model

// >>> verification/test_data_space_access_stack_check.sv
// Self-checking bench for the data-space access and stack check unit
`timescale 1ns/1ps
module test_data_space_access_stack_check;
    import dsa_pkg::*;
    logic clk, rstn, ce, acc_rd, acc_wr, acc_byte, acc_brev, acc_postinc, mac_rd;
    logic stk_push, stk_pop, ext_valid, ext_sign, reg_wr, reg_rd;
    logic [1:0] acc_dir_mode, stk_kind, reg_addr;
    logic [15:0] acc_ea, acc_wdata, acc_wreg_old, mac_x_ea, mac_y_ea, stk_wdata, ext_src;
    logic [15:0] reg_wdata, mem_x_rdata, mem_y_rdata;
    logic [7:0] pc_upper, status_low_byte;
    logic [15:0] reg_rdata_q, mem_x_wdata_q, x_rdata_q, wreg_new_q, y_rdata_q;
    logic [15:0] ptr_next_q, ext_result_q;
    logic [14:0] mem_x_addr_q, mem_y_addr_q;
    logic [1:0] mem_x_we_q;
    logic mem_x_re_q, mem_y_re_q, rd_valid_q, y_valid_q, addr_err_q, stack_err_q;
    int num_errors = 0;
    int num_checks = 0;

    dsa_top uut (.*);

    dsa_mem_model mem (.clk(clk), .x_addr(mem_x_addr_q), .x_re(mem_x_re_q),
        .x_we(mem_x_we_q), .x_wdata(mem_x_wdata_q), .y_addr(mem_y_addr_q),
        .y_re(mem_y_re_q), .x_rdata(mem_x_rdata), .y_rdata(mem_y_rdata));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results;
        begin
            $display("checks %0d mismatches %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        begin
            num_checks++;
            if (got !== exp)
            begin
                num_errors++;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    // Bounded wait for a read result pulse
    task automatic wait_v(input logic y);
        int n;
        begin
            n = 0;
            while (((y ? y_valid_q : rd_valid_q) !== 1'b1) && n < 8)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            if (n == 8)
            begin
                num_errors++;
                $display("CHECK FAILED read valid expected 1 seen 0");
                results();
            end
        end
    endtask

    task automatic acc(input logic rd, input logic wr, input logic by, input logic [1:0] md,
        input logic [15:0] ea, input logic [15:0] wd, input logic br);
        begin
            @(posedge clk);
            acc_rd <= rd;
            acc_wr <= wr;
            acc_byte <= by;
            acc_dir_mode <= md;
            acc_ea <= ea;
            acc_wdata <= wd;
            acc_brev <= br;
            @(posedge clk);
            acc_rd <= 1'b0;
            acc_wr <= 1'b0;
            #1;
        end
    endtask

    task automatic rw(input logic [1:0] a, input logic [15:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
            // idle cycle before any stack access
            @(posedge clk);
        end
    endtask

    task automatic rr(input logic [1:0] a, input logic [15:0] exp);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            chk("reg_rdata_q", exp, reg_rdata_q);
        end
    endtask

    task automatic stk(input logic pop, input logic [1:0] k, input logic [15:0] d);
        begin
            @(posedge clk);
            stk_push <= ~pop;
            stk_pop <= pop;
            stk_kind <= k;
            stk_wdata <= d;
            @(posedge clk);
            stk_push <= 1'b0;
            stk_pop <= 1'b0;
            #1;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        begin
            rw(DSA_REG_STACK_LIMIT, 16'h0803);
            rr(DSA_REG_STACK_LIMIT, 16'h0802);
            rr(DSA_REG_SP, DSA_SP_RST);
            rr(2'h3, 16'h0000);
            $display("test regs done");
        end
    endtask

    task automatic t_lanes;
        begin
            acc(0, 1, 0, DSA_DIR_IND, 16'h0100, 16'hA55A, 0);
            chk("we word", 16'h0003, {14'h0, mem_x_we_q});
            chk("addr", 16'h0080, {1'b0, mem_x_addr_q});
            chk("ptr word", 16'h0102, ptr_next_q);
            acc(0, 1, 1, DSA_DIR_IND, 16'h0101, 16'h003C, 0);
            chk("we byte", 16'h0002, {14'h0, mem_x_we_q});
            chk("ptr byte", 16'h0102, ptr_next_q);
            acc(1, 0, 1, DSA_DIR_IND, 16'h0101, 16'h0000, 0);
            wait_v(0);
            chk("byte hi", 16'h003C, x_rdata_q);
            chk("merge", 16'hBE3C, wreg_new_q);
            acc(1, 0, 0, DSA_DIR_IND, 16'h0100, 16'h0000, 0);
            wait_v(0);
            chk("word", 16'h3C5A, x_rdata_q);
            acc(0, 1, 0, DSA_DIR_IND, 16'h0004, 16'h1111, 1);
            chk("brev wr", 16'h0040, {1'b0, mem_x_addr_q});
            acc(1, 0, 0, DSA_DIR_IND, 16'h0080, 16'h0000, 1);
            chk("brev rd", 16'h0040, {1'b0, mem_x_addr_q});
            wait_v(0);
            chk("brev data", 16'h1111, x_rdata_q);
            acc(0, 1, 0, DSA_DIR_NEAR, 16'h2104, 16'h2222, 0);
            chk("near", 16'h0082, {1'b0, mem_x_addr_q});
            acc(1, 0, 0, DSA_DIR_LONG, 16'h0F00, 16'h0000, 0);
            chk("long", 16'h0780, {1'b0, mem_x_addr_q});
            wait_v(0);
            $display("test lanes done");
        end
    endtask

    task automatic t_fault;
        begin
            acc(0, 1, 0, DSA_DIR_IND, 16'h0103, 16'hFFFF, 0);
            chk("odd we", 16'h0000, {14'h0, mem_x_we_q});
            chk("addr err", 16'h0001, {15'h0, addr_err_q});
            chk("stk err", 16'h0000, {15'h0, stack_err_q});
            @(posedge clk);
            #1;
            chk("err pulse", 16'h0000, {15'h0, addr_err_q});
            acc(1, 0, 0, DSA_DIR_IND, 16'h0103, 16'h0000, 0);
            chk("rd err", 16'h0001, {15'h0, addr_err_q});
            wait_v(0);
            acc(1, 0, 0, DSA_DIR_IND, 16'h2000, 16'h0000, 0);
            chk("unimpl re", 16'h0000, {15'h0, mem_x_re_q});
            wait_v(0);
            chk("unimpl data", 16'h0000, x_rdata_q);
            rr(DSA_REG_FAULT, 16'h0001);
            rw(DSA_REG_FAULT, 16'h0003);
            rr(DSA_REG_FAULT, 16'h0000);
            $display("test fault done");
        end
    endtask

    task automatic t_mac(input logic [15:0] xa, input logic [15:0] ya, input logic [15:0] xe,
        input logic [15:0] ye);
        begin
            @(posedge clk);
            mac_rd <= 1'b1;
            mac_x_ea <= xa;
            mac_y_ea <= ya;
            @(posedge clk);
            mac_rd <= 1'b0;
            #1;
            wait_v(1);
            chk("mac x", xe, x_rdata_q);
            chk("mac y", ye, y_rdata_q);
        end
    endtask

    task automatic t_stack;
        begin
            rw(DSA_REG_STACK_LIMIT, 16'h0802);
            stk(0, DSA_PUSH_DATA, 16'h1234);
            chk("push addr", 16'h0400, {1'b0, mem_x_addr_q});
            chk("push data", 16'h1234, mem_x_wdata_q);
            stk(0, DSA_PUSH_CALL, 16'hFFFF);
            chk("call data", 16'h005A, mem_x_wdata_q);
            chk("at limit", 16'h0000, {15'h0, stack_err_q});
            rw(DSA_REG_STACK_LIMIT, 16'h0FFE);
            stk(0, DSA_PUSH_EXC, 16'hFFFF);
            chk("exc data", 16'hC35A, mem_x_wdata_q);
            rw(DSA_REG_STACK_LIMIT, 16'h0802);
            stk(0, DSA_PUSH_DATA, 16'h5555);
            chk("overflow", 16'h0001, {15'h0, stack_err_q});
            rw(DSA_REG_SP, 16'h0804);
            stk(1, DSA_PUSH_DATA, 16'h0000);
            chk("pop addr", 16'h0401, {1'b0, mem_x_addr_q});
            wait_v(0);
            chk("pop data", 16'h005A, x_rdata_q);
            rr(DSA_REG_SP, 16'h0802);
            rw(DSA_REG_SP, 16'h07FE);
            stk(0, DSA_PUSH_DATA, 16'h0000);
            chk("underflow", 16'h0001, {15'h0, stack_err_q});
            $display("test stack done");
        end
    endtask

    task automatic t_ext(input logic s, input logic [15:0] src, input logic [15:0] exp);
        begin
            @(posedge clk);
            ext_valid <= 1'b1;
            ext_sign <= s;
            ext_src <= src;
            @(posedge clk);
            ext_valid <= 1'b0;
            #1;
            chk("ext", exp, ext_result_q);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rstn, acc_rd, acc_wr, acc_byte, acc_brev, mac_rd, stk_push, stk_pop} = '0;
        {ext_valid, ext_sign, reg_wr, reg_rd, acc_dir_mode, stk_kind, reg_addr} = '0;
        {acc_ea, acc_wdata, mac_x_ea, mac_y_ea, stk_wdata, ext_src, reg_wdata} = '0;
        ce = 1'b1;
        acc_postinc = 1'b1;
        acc_wreg_old = 16'hBEEF;
        pc_upper = 8'h5A;
        status_low_byte = 8'hC3;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_lanes();
        t_fault();
        // Y address written over the X bus, then fetched by the Y pointer pair while the X pair reads zero from Y space
        acc(0, 1, 0, DSA_DIR_IND, 16'h0C02, 16'h7777, 0);
        t_mac(16'h0C00, 16'h0C02, 16'h0000, 16'h7777);
        t_mac(16'h0100, 16'h0100, 16'h3C5A, 16'h0000);
        $display("test mac done");
        t_stack();
        t_ext(1'b1, 16'h0080, 16'hFF80);
        t_ext(1'b0, 16'h1280, 16'h0080);
        @(posedge clk);
        ce <= 1'b0;
        t_ext(1'b1, 16'h0001, 16'h0080);
        $display("test ext done");
        results();
    end
endmodule // test_data_space_access_stack_check
